// file: src/sigext_params.svh
`ifndef SIGEXT_PARAMS_SVH
`define SIGEXT_PARAMS_SVH
`define OFF_CFG        8'h50
`define OFF_STAT       8'h51
`define OFF_ADDR       8'h52
`define OFF_DATA       8'h53
`define CFG_RESET      8'h00
`define CFG_VIEW_BIT   6
`define CFG_IRQEN_BIT  5
`define CFG_ESF_BIT    2
`define CFG_IND_BIT    1
`define CFG_PER_CHANNEL_CONFIG_ENABLE_BIT   0
`define CFG_WMASK      8'h67
`define BUSY_BIT       7
`define RNW_BIT        7
`define SEG1_LIMIT     7'h10
`define CFG_LO         7'h40
`define CFG_HI         7'h5F
`define ACCESS_CYCLES  4
`endif

// file: src/sigext_pkg.sv
package sigext_pkg;
  typedef struct packed {
    logic       valid;
    logic       readNotWrite;
    logic [6:0] index;
    logic [7:0] wdata;
  } store_req_s;
  typedef struct packed {
    logic       done;
    logic [7:0] rdata;
  } store_rsp_s;
endpackage : sigext_pkg

// file: src/sigext_store.sv
`timescale 1ns/1ps
`include "sigext_params.svh"
module sigext_store
  import sigext_pkg::*;
#(
  parameter int DEPTH   = 128,
  parameter int LATENCY = `ACCESS_CYCLES
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       clkEn,
  // Request and answer.
  input  wire store_req_s req,
  output      store_rsp_s rsp,
  // Current signaling nibbles, one per channel, for entries 10H to 1FH.
  input  wire logic [127:0] sigNibbles
);
  initial begin
    if (DEPTH != 128 || LATENCY < 1 || LATENCY > 15) begin
      $error("sigext_store: unsupported parameters");
    end
  end
  logic [7:0] mem [DEPTH];
  logic [3:0] cnt_q;
  logic       rnw_q;
  logic [6:0] idx_q;
  logic [7:0] wd_q;
  logic [7:0] rdVal;
  // Signaling entries pair channel n with channel n+16.
  always_comb begin
    rdVal = mem[idx_q];
    if (idx_q < 7'h20) begin
      rdVal = {sigNibbles[{idx_q[3:0], 2'b00} +: 4],
               sigNibbles[{1'b1, idx_q[3:0], 2'b00} +: 4]};
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 4'h0;
      rnw_q <= 1'b0;
      idx_q <= 7'h00;
      wd_q  <= 8'h00;
      rsp   <= '0;
    end else if (clkEn) begin
      rsp.done <= 1'b0;
      if (req.valid && cnt_q == 4'h0) begin
        cnt_q <= 4'(LATENCY);
        rnw_q <= req.readNotWrite;
        idx_q <= req.index;
        wd_q  <= req.wdata;
      end else if (cnt_q == 4'h1) begin
        cnt_q    <= 4'h0;
        rsp.done <= 1'b1;
        if (rnw_q) begin
          rsp.rdata <= rdVal;
        end
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
  // Array without reset keeps it mappable to RAM.
  always_ff @(posedge clk) begin
    if (clkEn && cnt_q == 4'h1 && !rnw_q && idx_q >= 7'h20) begin
      mem[idx_q] <= wd_q;
    end
  end
endmodule : sigext_store

// file: src/signaling_extract_reg_access.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "sigext_params.svh"
// Summary of operation
// - View bit selects change flags or indirect.
// - Enabled signaling change drives low interrupt.
// - Format bit selects EXTENDED_SUPERFRAME_SELECT, T1 only.
// - Per-channel config enable drives perChannelConfigActive; it does not gate entries 40H-5FH.
// - Flags for timeslots 26-31, read clears.
// - Flags for timeslots 18-25, read clears.
// - T1 channels numbered 1 to 24.
// - Busy reads one during indirect access.
// - Status at local address 1, indirect view.
// - Address write launches access by index.
// - Bit 7 one reads, zero writes.
// - Segment 1 index starts no access.
// - Direct mode address access starts nothing.
// - Flags 9-16 and 1-8, read clears.
// - Data register holds write value, read result.
module signaling_extract_reg_access
  import sigext_pkg::*;
#(
  parameter int CHANNELS = 31
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        clkEn,
  // Register port.
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wrData,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  output      logic [7:0]  rdData,
  // Signaling path.
  input  wire logic        e1ModeSelect,
  input  wire logic [31:1] sigChange,
  input  wire logic [127:0] sigNibbles,
  // Controls to the stream logic.
  output      logic        extendedSuperframe,
  output      logic        perChannelConfigActive,
  output      logic        interruptOut_n
);
  initial begin
    if (CHANNELS != 31) begin
      $error("signaling_extract_reg_access: CHANNELS must be 31");
    end
  end

  logic [7:0]  cfg_q;
  logic [7:0]  addrCtl_q;
  logic [7:0]  data_q;
  logic        busy_q;
  logic [30:1] flags_q;
  store_req_s  req_q;
  store_rsp_s  rsp;
  logic        viewChange;
  logic [30:1] flagEvent;
  logic [30:1] flagClear;
  logic        cfgWr;
  logic        addrWr;
  logic        dataWr;
  logic        launch;

  assign viewChange = cfg_q[`CFG_VIEW_BIT];
  assign cfgWr  = wrStb && addr == `OFF_CFG;
  assign addrWr = wrStb && addr == `OFF_ADDR && !viewChange;
  assign dataWr = wrStb && addr == `OFF_DATA && !viewChange;
  // Segment 1 entries and direct mode never reach the store.
  assign launch = addrWr && cfg_q[`CFG_IND_BIT]
                  && wrData[6:0] >= `SEG1_LIMIT;

  // E1 skips timeslots 0 and 16; T1 channel n lands on flag n.
  always_comb begin
    flagEvent = '0;
    if (e1ModeSelect) begin
      flagEvent[15:1]  = sigChange[15:1];
      flagEvent[30:16] = sigChange[31:17];
    end else begin
      flagEvent[24:1]  = sigChange[24:1];
    end
  end

  always_comb begin
    flagClear = '0;
    if (rdStb && viewChange) begin
      case (addr)
        `OFF_CFG:  flagClear[30:25] = '1;
        `OFF_STAT: flagClear[24:17] = '1;
        `OFF_ADDR: flagClear[16:9]  = '1;
        `OFF_DATA: flagClear[8:1]   = '1;
        default:   flagClear = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= `CFG_RESET;
    end else if (clkEn && cfgWr) begin
      cfg_q <= wrData & `CFG_WMASK;
    end
  end

  // A new event wins over the clearing read.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= '0;
    end else if (clkEn) begin
      flags_q <= (flags_q & ~flagClear) | flagEvent;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addrCtl_q <= 8'h00;
      busy_q    <= 1'b0;
      req_q     <= '0;
    end else if (clkEn) begin
      req_q.valid <= 1'b0;
      if (addrWr) begin
        addrCtl_q <= wrData;
      end
      if (launch && !busy_q) begin
        busy_q             <= 1'b1;
        req_q.valid        <= 1'b1;
        req_q.readNotWrite <= wrData[`RNW_BIT];
        req_q.index        <= wrData[6:0];
        req_q.wdata        <= data_q;
      end else if (rsp.done) begin
        busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_q <= 8'h00;
    end else if (clkEn) begin
      if (rsp.done && req_q.readNotWrite) begin
        data_q <= rsp.rdata;
      end else if (dataWr) begin
        data_q <= wrData;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData <= 8'h00;
    end else if (clkEn) begin
      rdData <= 8'h00;
      if (rdStb) begin
        case (addr)
          `OFF_CFG: begin
            if (viewChange) begin
              rdData <= {1'b0, 1'b1, flags_q[30:25]};
            end else begin
              rdData <= cfg_q;
            end
          end
          `OFF_STAT: begin
            if (viewChange) begin
              rdData <= flags_q[24:17];
            end else begin
              rdData <= {busy_q, 7'h00};
            end
          end
          `OFF_ADDR: begin
            rdData <= viewChange ? flags_q[16:9] : addrCtl_q;
          end
          `OFF_DATA: begin
            rdData <= viewChange ? flags_q[8:1] : data_q;
          end
          default: rdData <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      extendedSuperframe     <= 1'b0;
      perChannelConfigActive <= 1'b0;
      interruptOut_n         <= 1'b1;
    end else if (clkEn) begin
      extendedSuperframe <= cfg_q[`CFG_ESF_BIT] && !e1ModeSelect;
      perChannelConfigActive <= cfg_q[`CFG_PER_CHANNEL_CONFIG_ENABLE_BIT];
      interruptOut_n <= !(cfg_q[`CFG_IRQEN_BIT]
                          && |flags_q);
    end
  end

  sigext_store #(
    .DEPTH   (128),
    .LATENCY (`ACCESS_CYCLES)
  ) store (
    .clk        (clk),
    .rst_b      (rst_b),
    .clkEn      (clkEn),
    .req        (req_q),
    .rsp        (rsp),
    .sigNibbles (sigNibbles)
  );

  // These checks watch only what this block drives.
  a_busy_ends: assert property (
    @(posedge clk) disable iff (!rst_b)
    $rose(busy_q) |-> ##[1:8] !busy_q)
    else $error("busy did not clear");
  a_busy_hold: assert property (
    @(posedge clk) disable iff (!rst_b)
    (busy_q && !rsp.done) |=> busy_q)
    else $error("busy dropped before the access ended");
  a_seg1_idle: assert property (
    @(posedge clk) disable iff (!rst_b)
    (clkEn && addrWr && wrData[6:0] < `SEG1_LIMIT && !busy_q)
    |=> !busy_q)
    else $error("segment 1 index started an access");
  a_direct_idle: assert property (
    @(posedge clk) disable iff (!rst_b)
    (clkEn && addrWr && !cfg_q[`CFG_IND_BIT] && !busy_q)
    |=> !busy_q)
    else $error("direct mode started an access");
  a_launch_busy: assert property (
    @(posedge clk) disable iff (!rst_b)
    (clkEn && launch && !busy_q) |=> busy_q)
    else $error("launch did not set busy");
  a_status_read: assert property (
    @(posedge clk) disable iff (!rst_b)
    (clkEn && rdStb && !viewChange && addr == `OFF_STAT)
    |=> rdData == {$past(busy_q), 7'h00})
    else $error("status read does not show busy");
  a_cfg_read: assert property (
    @(posedge clk) disable iff (!rst_b)
    (clkEn && rdStb && !viewChange && addr == `OFF_CFG)
    |=> rdData == $past(cfg_q))
    else $error("indirect view does not show config");
  a_flag_clear: assert property (
    @(posedge clk) disable iff (!rst_b)
    (clkEn && rdStb && viewChange && addr == `OFF_DATA
     && sigChange[8:1] == 8'h00) |=> flags_q[8:1] == 8'h00)
    else $error("flags 1-8 not cleared by read");
  a_mid_clear: assert property (
    @(posedge clk) disable iff (!rst_b)
    (clkEn && rdStb && viewChange && addr == `OFF_STAT
     && sigChange[25:17] == 9'h000) |=> flags_q[24:17] == 8'h00)
    else $error("flags 17-24 not cleared by read");
  a_hi_clear: assert property (
    @(posedge clk) disable iff (!rst_b)
    (clkEn && rdStb && viewChange && addr == `OFF_CFG
     && sigChange[31:26] == 6'h00) |=> flags_q[30:25] == 6'h00)
    else $error("flags 25-30 not cleared by read");
  a_flag_set: assert property (
    @(posedge clk) disable iff (!rst_b)
    (clkEn && !e1ModeSelect && sigChange[20]) |=> flags_q[20])
    else $error("channel change not flagged");
  a_t1_last: assert property (
    @(posedge clk) disable iff (!rst_b)
    (clkEn && !e1ModeSelect && sigChange[24]) |=> flags_q[24])
    else $error("last channel change not flagged");
  a_e1_top: assert property (
    @(posedge clk) disable iff (!rst_b)
    (clkEn && e1ModeSelect && sigChange[31]) |=> flags_q[30])
    else $error("top timeslot change not flagged");
  a_t1_top: assert property (
    @(posedge clk) disable iff (!rst_b)
    (clkEn && !e1ModeSelect && flags_q[30:25] == 6'h00)
    |=> flags_q[30:25] == 6'h00)
    else $error("top flags set outside E1 mode");
  a_irq_mask: assert property (
    @(posedge clk) disable iff (!rst_b)
    (clkEn && !cfg_q[`CFG_IRQEN_BIT]) |=> interruptOut_n)
    else $error("interrupt not suppressed");
  a_irq_hold: assert property (
    @(posedge clk) disable iff (!rst_b)
    (clkEn && cfg_q[`CFG_IRQEN_BIT] && |flags_q) |=> !interruptOut_n)
    else $error("interrupt not raised");
  a_esf_e1: assert property (
    @(posedge clk) disable iff (!rst_b)
    (clkEn && e1ModeSelect) |=> !extendedSuperframe)
    else $error("format bit not ignored in E1 mode");
  a_pcc_off: assert property (
    @(posedge clk) disable iff (!rst_b)
    (clkEn && !cfg_q[`CFG_PER_CHANNEL_CONFIG_ENABLE_BIT]) |=> !perChannelConfigActive)
    else $error("per-channel config active while disabled");
  a_data_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    (clkEn && dataWr && !rsp.done) |=> data_q == $past(wrData))
    else $error("write value not held in data register");
  a_read_data: assert property (
    @(posedge clk) disable iff (!rst_b)
    (clkEn && rsp.done && req_q.readNotWrite) |=> data_q == $past(rsp.rdata))
    else $error("read result not captured");

  c_read: cover property (@(posedge clk) rsp.done && req_q.readNotWrite);
  c_write: cover property (@(posedge clk) rsp.done && !req_q.readNotWrite);
  c_irq: cover property (@(posedge clk) $fell(interruptOut_n));
  c_freeze: cover property (@(posedge clk) !clkEn && wrStb);
  c_clear: cover property (@(posedge clk) |flagClear && |flags_q);
endmodule : signaling_extract_reg_access

// file: tb/sig_source.sv
`timescale 1ns/1ps
module sig_source (
  // Clock.
  input  wire logic         clk,
  // Signaling toward the block.
  output      logic [31:1]  sigChange,
  output      logic [127:0] sigNibbles
);
  // Nibbles n and n+16 differ for every n but 5, so a swapped half of any entry but 15H shows up.
  initial begin
    sigChange  = '0;
    sigNibbles = 128'hFEDCBA9876543210_0F1E2D3C4B5A6978;
  end
  // One-cycle change event on a slot, launched after a rising edge.
  task automatic pulse(input int slot);
    @(posedge clk);
    sigChange[slot] <= 1'b1;
    @(posedge clk);
    sigChange <= '0;
  endtask : pulse
endmodule : sig_source

// file: tb/signaling_extract_reg_access_test.sv
`timescale 1ns/1ps
module signaling_extract_reg_access_test;
  logic         clk;
  logic         rst_b;
  logic [7:0]   addr;
  logic [7:0]   wrData;
  logic [7:0]   rdData;
  logic [7:0]   q;
  logic         wrStb;
  logic         rdStb;
  logic         clkEn;
  logic         e1;
  logic         extended_superframe_select;
  logic         pcc;
  logic         irqN;
  logic [31:1]  sigChange;
  logic [127:0] sigNibbles;
  int           errorCnt;
  int           checks;

  signaling_extract_reg_access DUT (.clk(clk), .rst_b(rst_b), .clkEn(clkEn),
    .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
    .rdData(rdData), .e1ModeSelect(e1), .sigChange(sigChange),
    .sigNibbles(sigNibbles), .extendedSuperframe(extended_superframe_select),
    .perChannelConfigActive(pcc), .interruptOut_n(irqN));
  sig_source src (.clk(clk), .sigChange(sigChange), .sigNibbles(sigNibbles));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
    @(posedge clk);
  endtask : wr

  // Read data only stand in the cycle after the strobe, so look there.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 d = rdData;
    @(posedge clk);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic results;
    $display("errors %0d checks %0d", errorCnt, checks);
    if (errorCnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // Bounded busy poll; a stuck busy ends the run at once.
  task automatic poll;
    for (int i = 0; i < 20; i++) begin
      rd(8'h51, q);
      if (q[7] === 1'b0) return;
    end
    chk("busy", 8'h00, q);
    results();
  endtask : poll

  logic [7:0] idx [2] = '{8'h40, 8'h5F};
  logic [7:0] val [2] = '{8'hA5, 8'h3C};

  initial begin
    errorCnt = 0;
    checks = 0;
    rst_b = 1'b0;
    addr = '0;
    wrData = '0;
    wrStb = 1'b0;
    rdStb = 1'b0;
    clkEn = 1'b1;
    e1 = 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    settle(1);
    chk("pcc", 8'h00, {7'h0, pcc});
    chk("irqN", 8'h01, {7'h0, irqN});
    rd(8'h50, q);
    chk("cfg", 8'h00, q);
    wr(8'h50, 8'h27);
    rd(8'h50, q);
    chk("cfg", 8'h27, q);
    clkEn <= 1'b0;
    wr(8'h50, 8'h00);
    clkEn <= 1'b1;
    rd(8'h50, q);
    chk("frozen", 8'h27, q);
    chk("esf", 8'h01, {7'h0, extended_superframe_select});
    chk("pcc", 8'h01, {7'h0, pcc});
    e1 <= 1'b1;
    settle(2);
    chk("esf", 8'h00, {7'h0, extended_superframe_select});
    wr(8'h52, 8'h92);
    rd(8'h51, q);
    chk("busy", 8'h80, q);
    poll();
    rd(8'h53, q);
    chk("cur", {sigNibbles[11:8], sigNibbles[75:72]}, q);
    for (int i = 0; i < 2; i++) begin
      wr(8'h53, val[i]);
      wr(8'h52, idx[i]);
      poll();
      wr(8'h53, 8'h00);
      wr(8'h52, idx[i] | 8'h80);
      poll();
      rd(8'h53, q);
      chk("entry", val[i], q);
    end
    wr(8'h52, 8'h85);
    rd(8'h51, q);
    chk("seg1", 8'h00, q);
    wr(8'h50, 8'h25);
    wr(8'h52, 8'h92);
    rd(8'h51, q);
    chk("direct", 8'h00, q);
    rd(8'h60, q);
    chk("unmapped", 8'h00, q);
    wr(8'h50, 8'h62);
    src.pulse(26);
    src.pulse(31);
    src.pulse(18);
    src.pulse(17);
    src.pulse(1);
    settle(3);
    chk("irqN", 8'h00, {7'h0, irqN});
    rd(8'h50, q);
    chk("flagsHi", 8'h61, q);
    rd(8'h50, q);
    chk("flagsHi", 8'h40, q);
    chk("irqN", 8'h00, {7'h0, irqN});
    rd(8'h51, q);
    chk("flagsMid", 8'h01, q);
    rd(8'h52, q);
    chk("flags16", 8'h80, q);
    rd(8'h53, q);
    chk("flags8", 8'h01, q);
    settle(2);
    chk("irqN", 8'h01, {7'h0, irqN});
    e1 <= 1'b0;
    src.pulse(24);
    src.pulse(20);
    settle(3);
    rd(8'h51, q);
    chk("t1Ch24", 8'h88, q);
    wr(8'h50, 8'h43);
    src.pulse(1);
    settle(3);
    chk("irqN", 8'h01, {7'h0, irqN});
    chk("pcc", 8'h01, {7'h0, pcc});
    rd(8'h53, q);
    chk("flags8", 8'h01, q);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    settle(1);
    chk("pcc", 8'h00, {7'h0, pcc});
    rd(8'h50, q);
    chk("cfgRst", 8'h00, q);
    results();
  end
endmodule : signaling_extract_reg_access_test
